// [odf_pkg.sv]
// Purpose: Shared constants and carrier types for the output data formatter.
// Assumes: One 12-bit sample word plus an overrange bit per sample.
// Notes:   The configuration register resets to all zeros.

package odf_pkg;

  // ==========================================================================
  // Register map
  localparam logic [7:0] ODF_FORMAT_ADDR = 8'h04;
  localparam logic [7:0] ODF_FORMAT_RESET = 8'h00;
  localparam logic [7:0] ODF_FORMAT_USED_MASK = 8'h3f;

  // ==========================================================================
  // Field positions inside the format register
  localparam int ODF_SIGNED_BIT = 0;
  localparam int ODF_SCRAMBLE_BIT = 1;
  localparam int ODF_POLARITY_BIT = 2;
  localparam int ODF_PATTERN_LSB = 3;
  localparam int ODF_PATTERN_MSB = 5;

  // ==========================================================================
  // Sample word layout and test pattern codes
  localparam int ODF_SAMPLE_W = 12;

  localparam logic [2:0] ODF_PAT_OFF = 3'h0;
  localparam logic [2:0] ODF_PAT_ZERO = 3'h1;
  localparam logic [2:0] ODF_PAT_ONE = 3'h3;
  localparam logic [2:0] ODF_PAT_CHECKER = 3'h5;
  localparam logic [2:0] ODF_PAT_ALTERNATE = 3'h7;

  localparam logic [12:0] ODF_WORD_ZEROS = 13'h0000;
  localparam logic [12:0] ODF_WORD_ONES = 13'h1fff;
  localparam logic [12:0] ODF_CHECKER_A = 13'h1555;
  localparam logic [12:0] ODF_CHECKER_B = 13'h0aaa;

  // Bits inverted in alternate bit polarity mode (every odd bit).
  localparam logic [11:0] ODF_POLARITY_MASK = 12'haaa;

  typedef struct packed {
    logic overrange_flag;
    logic [ODF_SAMPLE_W-1:0] sample_bits;
  } odf_word_t;

  // Mirrors bits 5..0 of the format register.
  typedef struct packed {
    logic [2:0] test_pattern_select;
    logic bit_polarity_alternation;
    logic output_scrambler_enable;
    logic signed_format_select;
  } odf_cfg_t;

endpackage

// [odf_skid_buf.sv]
// Purpose: Two-entry buffer with valid and ready on both sides.
// Assumes: Single clock, synchronous active-low reset.
// Notes:   All outputs come from flip-flops; no word is lost on a stall.

`timescale 1ns/1ps
`default_nettype none

module odf_skid_buf #(
  parameter int WIDTH = 13
) (
  input wire logic mclk,               // System clock.
  input wire logic nrst,               // Synchronous reset, active low.
  input wire logic s_valid,            // Source offers a word.
  output logic s_ready,                // Buffer can take a word.
  input wire logic [WIDTH-1:0] s_data, // Word from the source.
  output logic m_valid,                // Head word is valid.
  input wire logic m_ready,            // Sink takes the head word.
  output logic [WIDTH-1:0] m_data      // Head word.
);

  initial begin
    if (WIDTH < 1) begin
      $error("odf_skid_buf: WIDTH must be at least 1");
    end
  end

  logic spare_valid;
  logic [WIDTH-1:0] spare_data;
  logic next_spare_valid;
  logic [WIDTH-1:0] next_spare_data;
  logic next_m_valid;
  logic [WIDTH-1:0] next_m_data;
  logic push;
  logic pop;

  // ==========================================================================
  // Next state
  always_comb begin
    push = s_valid && s_ready;
    pop = m_valid && m_ready;
    next_m_valid = m_valid;
    next_m_data = m_data;
    next_spare_valid = spare_valid;
    next_spare_data = spare_data;
    if (spare_valid) begin
      if (pop) begin
        next_m_data = spare_data;
        next_spare_valid = 1'b0;
      end
    end else if (push) begin
      if (!m_valid || pop) begin
        next_m_data = s_data;
        next_m_valid = 1'b1;
      end else begin
        next_spare_data = s_data;
        next_spare_valid = 1'b1;
      end
    end else if (pop) begin
      next_m_valid = 1'b0;
    end
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      m_valid <= 1'b0;
      m_data <= '0;
      spare_valid <= 1'b0;
      spare_data <= '0;
      s_ready <= 1'b0;
    end else begin
      m_valid <= next_m_valid;
      m_data <= next_m_data;
      spare_valid <= next_spare_valid;
      spare_data <= next_spare_data;
      s_ready <= !next_spare_valid;
    end
  end

endmodule

`default_nettype wire

// [odf_output_formatter.sv]
// Purpose: Output data formatting stage of a 12-bit sampling converter.
// Assumes: Conversion words arrive synchronous to mclk with valid/ready.
// Notes:   One register at 04h steers test patterns, and the polarity,
//          scrambling and number format of every passed conversion word.

`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Pattern code 000 passes conversion results; undefined codes 010, 100 and 110 do the same.
// - Code 001 drives all outputs low; code 011 drives all outputs high.
// - Code 101 alternates overrange and sample between 1 0101.. and 0 1010...
// - Code 111 alternates overrange and sample between all zeros and all ones.
// - Bit 2 set enables alternate bit polarity on output data.
// - Bit 1 set enables the output randomizer; clear passes plain data.
// - Bit 0 clear gives offset binary; set gives two's complement.
// - Alternate bit polarity forces offset binary whatever bit 0 says.
module odf_output_formatter
  import odf_pkg::*;
(
  input wire logic mclk,             // System clock, 200 MHz.
  input wire logic nrst,             // Synchronous reset, active low.
  input wire logic reg_wr_en,        // Register write strobe.
  input wire logic reg_rd_en,        // Register read strobe.
  input wire logic [7:0] reg_addr,   // Register address.
  input wire logic [7:0] reg_wdata,  // Register write data.
  output logic [7:0] reg_rdata,      // Register read data.
  output logic reg_rd_valid,         // Read data valid pulse.
  input wire logic conv_valid,       // Conversion word offered.
  output logic conv_ready,           // Formatter takes the word.
  input wire odf_word_t conv_word,   // Raw conversion word.
  output logic data_valid,           // Formatted word valid.
  input wire logic data_ready,       // Capture side takes the word.
  output odf_word_t data_word        // Formatted output word.
);

  localparam int WORD_W = $bits(odf_word_t);

  initial begin
    if (ODF_SAMPLE_W < 2) begin
      $error("odf_output_formatter: sample width below 2 is not served");
    end
  end

  // ==========================================================================
  // Transform functions
  function automatic odf_word_t shape_word(input odf_word_t w,
                                           input odf_cfg_t c);
    odf_word_t r;
    r = w;
    // The core delivers offset binary; flipping the MSB gives two's
    // complement, but polarity alternation keeps offset binary.
    if (c.signed_format_select && !c.bit_polarity_alternation) begin
      r.sample_bits[ODF_SAMPLE_W-1] = ~r.sample_bits[ODF_SAMPLE_W-1];
    end
    // The randomizer folds the LSB into every higher bit; the capture side
    // undoes it by the same XOR with the received LSB.
    if (c.output_scrambler_enable) begin
      r.sample_bits[ODF_SAMPLE_W-1:1] = r.sample_bits[ODF_SAMPLE_W-1:1]
        ^ {(ODF_SAMPLE_W-1){r.sample_bits[0]}};
    end
    if (c.bit_polarity_alternation) begin
      r.sample_bits = r.sample_bits ^ ODF_POLARITY_MASK;
    end
    return r;
  endfunction

  function automatic logic is_alternating(input logic [2:0] code);
    return (code == ODF_PAT_CHECKER) || (code == ODF_PAT_ALTERNATE);
  endfunction

  // ==========================================================================
  // Configuration register
  logic [7:0] format_reg;
  logic [7:0] next_format_reg;
  logic [7:0] next_reg_rdata;
  logic next_reg_rd_valid;
  odf_cfg_t cfg;

  always_comb begin
    next_format_reg = format_reg;
    if (reg_wr_en && (reg_addr == ODF_FORMAT_ADDR)) begin
      next_format_reg = reg_wdata & ODF_FORMAT_USED_MASK;
    end
    next_reg_rd_valid = reg_rd_en;
    next_reg_rdata = 8'h00;
    if (reg_rd_en && (reg_addr == ODF_FORMAT_ADDR)) begin
      next_reg_rdata = format_reg;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      format_reg <= ODF_FORMAT_RESET;
      reg_rdata <= 8'h00;
      reg_rd_valid <= 1'b0;
    end else begin
      format_reg <= next_format_reg;
      reg_rdata <= next_reg_rdata;
      reg_rd_valid <= next_reg_rd_valid;
    end
  end

  assign cfg = odf_cfg_t'(format_reg[ODF_PATTERN_MSB:ODF_SIGNED_BIT]);

  // ==========================================================================
  // Word selection
  logic phase;
  logic next_phase;
  logic accept;
  logic buf_ready;
  odf_word_t formatted;

  // The word is built from the register as it stands when the word is
  // accepted, so a later write cannot touch a buffered or presented word.
  always_comb begin
    accept = conv_valid && buf_ready;
    unique case (cfg.test_pattern_select)
      ODF_PAT_ZERO: formatted = odf_word_t'(ODF_WORD_ZEROS);
      ODF_PAT_ONE: formatted = odf_word_t'(ODF_WORD_ONES);
      ODF_PAT_CHECKER: begin
        formatted = odf_word_t'(phase ? ODF_CHECKER_B
                                      : ODF_CHECKER_A);
      end
      ODF_PAT_ALTERNATE: begin
        formatted = odf_word_t'(phase ? ODF_WORD_ONES
                                      : ODF_WORD_ZEROS);
      end
      // Code 000 and every unused code pass conversion results.
      default: formatted = shape_word(conv_word, cfg);
    endcase
    next_phase = phase;
    if (accept) begin
      next_phase = is_alternating(cfg.test_pattern_select) ? ~phase
                                                           : 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      phase <= 1'b0;
    end else begin
      phase <= next_phase;
    end
  end

  // ==========================================================================
  // Output buffer
  logic [WORD_W-1:0] buf_out;

  odf_skid_buf #(
    .WIDTH(WORD_W)
  ) u_buf (
    .mclk(mclk),
    .nrst(nrst),
    .s_valid(conv_valid),
    .s_ready(buf_ready),
    .s_data(formatted),
    .m_valid(data_valid),
    .m_ready(data_ready),
    .m_data(buf_out)
  );

  assign conv_ready = buf_ready;
  assign data_word = odf_word_t'(buf_out);

endmodule

`default_nettype wire

// [odf_output_formatter_properties.sv]
// Purpose: Port assertions for the output data formatter.
// Assumes: A write lands on the edge that strobes it.
// Notes: fmt mirrors the format register.
`timescale 1ns/1ps
`default_nettype none
module odf_output_formatter_properties
  import odf_pkg::*;
(
  input wire logic mclk, // Clock.
  input wire logic nrst, // Reset, low.
  input wire logic reg_wr_en, // Write.
  input wire logic reg_rd_en, // Read.
  input wire logic [7:0] reg_addr, // Address.
  input wire logic [7:0] reg_wdata, // Write data.
  input wire logic [7:0] reg_rdata, // Read data.
  input wire logic reg_rd_valid, // Read valid.
  input wire logic conv_valid, // Word in.
  input wire logic conv_ready, // Taken.
  input wire odf_word_t conv_word, // Raw word.
  input wire logic data_valid, // Word out.
  input wire logic data_ready, // Sink ready.
  input wire odf_word_t data_word // Formatted.
);
  // =========
  // Register mirror
  logic [7:0] fmt;
  logic [7:0] next_fmt;
  always_comb begin
    next_fmt = fmt;
    if (reg_wr_en && reg_addr == ODF_FORMAT_ADDR)
      next_fmt = reg_wdata & ODF_FORMAT_USED_MASK;
  end
  always_ff @(posedge mclk) fmt <= nrst ? next_fmt : ODF_FORMAT_RESET;
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  sequence take(logic [5:0] c);
    conv_valid && conv_ready && !data_valid && !reg_wr_en && fmt[5:0] == c;
  endsequence
  chk_read_pulse: assert property (reg_rd_en |=> reg_rd_valid)
    else $error("read valid missing");
  chk_read_value: assert property (reg_rd_en && reg_addr == ODF_FORMAT_ADDR
    |=> reg_rdata == $past(fmt)) else $error("format readback wrong");
  chk_read_unmapped: assert property (reg_rd_en && reg_addr != ODF_FORMAT_ADDR
    |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
  chk_word_hold: assert property (
    data_valid && !data_ready |=> data_valid && $stable(data_word))
    else $error("stalled word changed");
  chk_plain_pass: assert property (
    take(6'h00) |=> data_word == $past(conv_word)) else $error("plain bad");
  chk_pattern_low: assert property (
    take(6'h08) |=> data_word == 13'h0000) else $error("low pattern bad");
  chk_pattern_high: assert property (
    take(6'h18) |=> data_word == 13'h1fff) else $error("high pattern bad");
  chk_signed_msb: assert property (
    take(6'h01) |=> data_word == ($past(conv_word) ^ 13'h0800))
    else $error("signed format bad");
  chk_polarity_wins: assert property (
    take(6'h05) |=> data_word == ($past(conv_word) ^ 13'h0aaa))
    else $error("polarity format bad");
endmodule
bind odf_output_formatter odf_output_formatter_properties u_chk (.*);
`default_nettype wire

// [odf_capture_model.sv]
// Purpose: Capture side taking formatted words.
// Assumes: Ready moves just after a clock edge.
// Notes: slow takes every other cycle; stall takes nothing.
`timescale 1ns/1ps
`default_nettype none
module odf_capture_model (
  input wire logic mclk, // Clock.
  input wire logic nrst, // Reset, low.
  input wire logic stall, // Refuse all.
  input wire logic slow, // Half rate.
  input wire logic data_valid, // Word offered.
  output logic data_ready, // Accepting.
  output logic take // Taken now.
);
  always_ff @(posedge mclk)
    data_ready <= nrst && !stall && (!slow || !data_ready);
  assign take = data_valid && data_ready;
endmodule
`default_nettype wire

// [test_odf_output_formatter.sv]
// Purpose: Self-checking bench for the output data formatter.
// Assumes: Expected words queue when the formatter takes them.
// Notes: Pattern phase is tracked here.
`timescale 1ns/1ps
`default_nettype none
module test_odf_output_formatter
  import odf_pkg::*;
;
  logic mclk = 0;
  logic nrst = 0;
  logic reg_wr_en = 0, reg_rd_en = 0, conv_valid = 0, stall = 0, slow = 0;
  logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata;
  logic reg_rd_valid, conv_ready, data_valid, data_ready, take;
  odf_word_t conv_word = 0, data_word;
  odf_word_t exp_q[$];
  logic [5:0] cfg = 0;
  logic ph = 0;
  int errors = 0, samples_checked = 0;
  logic [5:0] cfgs[12] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 6'h18, 6'h28, 6'h38};
  odf_word_t words[4] = '{13'h1001, 13'h0ffe, 13'h0000, 13'h1a5b};
  always #2.5 mclk = ~mclk;
  odf_output_formatter u_odf_output_formatter (.*);
  odf_capture_model u_odf_capture_model (.*);
  // =========
  // Tasks
  task automatic cmp(input logic [12:0] got, input logic [12:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr_en <= 1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr_en <= 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_rd_en <= 1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd_en <= 0;
    @(posedge mclk);
    cmp({5'h0, reg_rdata}, {5'h0, exp});
  endtask
  function automatic odf_word_t expw(input odf_word_t w);
    logic [11:0] s;
    s = w.sample_bits;
    case (cfg[5:3])
      3'h1: return 13'h0000;
      3'h3: return 13'h1fff;
      3'h5: return ph ? 13'h0aaa : 13'h1555;
      3'h7: return ph ? 13'h1fff : 13'h0000;
      default: begin
        if (cfg[0] && !cfg[2]) s[11] = ~s[11];
        if (cfg[1]) s[11:1] = s[11:1] ^ {11{s[0]}};
        if (cfg[2]) s = s ^ 12'haaa;
        return {w.overrange_flag, s};
      end
    endcase
  endfunction
  task automatic send(input odf_word_t w);
    int n;
    conv_valid <= 1;
    conv_word <= w;
    for (n = 0; n < 50; n++) begin
      @(posedge mclk);
      if (conv_ready) break;
    end
    if (n == 50) begin
      errors++;
      conclude();
    end
    exp_q.push_back(expw(w));
    ph = cfg[5] && cfg[3] && !ph;
  endtask
  task automatic drain;
    int n;
    conv_valid <= 0;
    for (n = 0; n < 60 && exp_q.size() > 0; n++) @(posedge mclk);
    if (exp_q.size() > 0) begin
      errors++;
      conclude();
    end
  endtask
  always @(posedge mclk)
    if (nrst && take) begin
      cmp(data_word, exp_q.size() > 0 ? exp_q.pop_front() : ~data_word);
    end
  // =========
  // Sequence
  initial begin
    repeat (3) @(posedge mclk);
    nrst <= 1;
    @(posedge mclk);
    rd(8'h04, 8'h00);
    wr(8'h04, 8'hff);
    rd(8'h04, 8'h3f);
    rd(8'h05, 8'h00);
    wr(8'h05, 8'h01);
    rd(8'h04, 8'h3f);
    foreach (cfgs[i]) begin
      wr(8'h04, {2'h0, cfgs[i]});
      cfg = cfgs[i];
      slow <= i[0];
      foreach (words[k]) send(words[k]);
      drain();
    end
    stall <= 1;
    send(words[0]);
    send(words[3]);
    conv_valid <= 0;
    @(posedge mclk);
    cmp({12'h0, conv_ready}, 13'h0);
    wr(8'h04, 8'h05);
    cfg = 6'h05;
    stall <= 0;
    drain();
    conclude();
  end
endmodule
`default_nettype wire
